/* verilog/csr_pkg.sv */
package csr_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MOD = 8'h04;
  localparam logic [7:0] ADDR_COUNT = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;

  // ==========================================================
  // Control fields
  localparam int CTRL_CIN = 0;
  localparam int CTRL_DIR = 1;
  localparam int CTRL_DEC = 2;
  localparam int CTRL_MODEN = 3;
  localparam int CTRL_SEL_LSB = 4;
  localparam int CTRL_INH = 7;
  localparam logic [31:0] CTRL_RST = 32'h0000_0003;
  localparam logic [31:0] MOD_RST = 32'h0000_0000;

  // ==========================================================
  // Status fields
  localparam int STAT_SIGN = 0;
  localparam int STAT_DIR = 1;
  localparam int STAT_MATCH = 2;
  localparam int STAT_CLR = 3;

  // ==========================================================
  // Digit limits
  localparam logic [3:0] DEC_MAX = 4'h9;
  localparam logic [3:0] HEX_MAX = 4'hf;

  // ==========================================================
  // Timing
  localparam int CLK_NS = 5;
  localparam int CLR_NS = 40;
  // Strictly longer than the figure, so one cycle beyond the round-up
  localparam int CLR_CYC = (CLR_NS + CLK_NS - 1) / CLK_NS + 1;
  localparam logic [4:0] CLR_CNT_LOAD = 5'(CLR_CYC);

endpackage

/* verilog/csr_top.sv */
`timescale 1ns/1ps

// Function
// - Sign latch takes requested direction whenever combined carry-out is high.
// - Applied direction is XNOR of requested direction and sign latch.
// - Count outputs hold magnitude; sign high for positive, low for negative; zero keeps the old sign.
// - Passing through zero restarts magnitude upward with the new sign.
// - All count outputs change together on one clock edge.
// - Each stage gives a true and complemented most significant bit.
// - Rate selector is an 8-bit counter of two chained 4-bit stages.
// - Select k picks stage k+1, dividing by two to the k+1.
// - Inhibit high drives both rate outputs low.
// - Rate outputs true and inverted with equal latency for every ratio.
// - Modulus match when counter stages equal the programmed word.
// - Match gives an active-low counter reset longer than 40 ns.
// - Carry-in low inhibits counting.
// - Later stages advance once per full cycle of the stage below.
module csr_top
  import csr_pkg::*;
#(
  parameter int STAGES = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [4*STAGES-1:0] count_o,
  output logic [STAGES-1:0] msb_n_o,
  output logic sign_o,
  output logic dir_o,
  output logic carry_o,
  output logic match_o,
  output logic clear_n_o,
  output logic rate_o,
  output logic rate_n_o
);

  localparam int W = 4 * STAGES;

  // Refused at elaboration: the mod word and read port are 32 bits wide
  if (STAGES < 1 || STAGES > 8) begin : g_bad_stages
    $error("csr_top: STAGES must lie in 1..8");
  end

  // ==========================================================
  // Digit helpers
  function automatic logic [3:0] digit_max(input logic dec);
    digit_max = dec ? DEC_MAX : HEX_MAX;
  endfunction

  function automatic logic digit_term(input logic [3:0] d, input logic up,
                                      input logic dec);
    digit_term = up ? (d == digit_max(dec)) : (d == 4'h0);
  endfunction

  function automatic logic [3:0] digit_step(input logic [3:0] d, input logic up,
                                            input logic dec);
    if (up) begin
      digit_step = (d >= digit_max(dec)) ? 4'h0 : 4'(d + 4'h1);
    end else begin
      digit_step = (d == 4'h0) ? digit_max(dec) : 4'(d - 4'h1);
    end
  endfunction

  function automatic logic [31:0] byte_merge(input logic [31:0] old,
                                             input logic [31:0] wr,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = wr[8*b +: 8];
      end
    end
    byte_merge = r;
  endfunction

  // ==========================================================
  // Registers
  logic [31:0] ctrl_ff;
  logic [31:0] mod_ff;
  logic [W-1:0] cnt_ff;
  logic sign_ff;
  logic [4:0] clr_ff;
  logic [7:0] div_ff;

  logic [W-1:0] nxt_cnt;
  logic nxt_sign;
  logic nxt_dir;
  logic carry;
  logic match;
  logic clr_active;
  logic [4:0] nxt_clr;
  logic wb_req;
  logic wb_wr;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Writes land on the edge that sees ack high, where the master ends the cycle
  assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign clr_active = (clr_ff != 5'h00);

  // ==========================================================
  // Wishbone slave: one wait state, ack for one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req && !wb_we_i) begin
      unique case (wb_adr_i)
        ADDR_CTRL: wb_dat_o <= ctrl_ff;
        ADDR_MOD: wb_dat_o <= mod_ff;
        ADDR_COUNT: wb_dat_o <= 32'(cnt_ff);
        ADDR_STAT: begin
          wb_dat_o <= 32'h0000_0000;
          wb_dat_o[STAT_SIGN] <= sign_ff;
          wb_dat_o[STAT_DIR] <= dir_o;
          wb_dat_o[STAT_MATCH] <= match_o;
          wb_dat_o[STAT_CLR] <= clr_active;
        end
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= CTRL_RST;
    end else if (wb_wr && wb_adr_i == ADDR_CTRL) begin
      ctrl_ff <= byte_merge(ctrl_ff, wb_dat_i, wb_sel_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mod_ff <= MOD_RST;
    end else if (wb_wr && wb_adr_i == ADDR_MOD) begin
      mod_ff <= byte_merge(mod_ff, wb_dat_i, wb_sel_i);
    end
  end

  // ==========================================================
  // Magnitude and sign counter
  // The real latch is transparent, so the new sign steers the very step
  // that leaves zero; here that is done by steering with nxt_sign.
  always_comb begin
    logic up_req;
    logic cin;
    logic dec;
    logic dir_old;
    logic all_term;
    logic en;
    up_req = ctrl_ff[CTRL_DIR];
    cin = ctrl_ff[CTRL_CIN];
    dec = ctrl_ff[CTRL_DEC];
    en = cin;
    dir_old = ~(up_req ^ sign_ff);
    all_term = 1'b1;
    for (int i = 0; i < STAGES; i++) begin
      all_term = all_term & digit_term(cnt_ff[4*i +: 4], dir_old, dec);
    end
    carry = cin && all_term;
    nxt_sign = carry ? up_req : sign_ff;
    nxt_dir = ~(up_req ^ nxt_sign);
    nxt_cnt = cnt_ff;
    for (int i = 0; i < STAGES; i++) begin
      if (en) begin
        nxt_cnt[4*i +: 4] = digit_step(cnt_ff[4*i +: 4], nxt_dir, dec);
      end
      en = en & digit_term(cnt_ff[4*i +: 4], nxt_dir, dec);
    end
    // The matching edge already loads zero, so no stray count shows under clear
    if (clr_active || match) begin
      nxt_cnt = '0;
    end
  end

  // Count and both MSB polarities load on the same edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      msb_n_o <= '1;
    end else begin
      for (int i = 0; i < STAGES; i++) begin
        msb_n_o[i] <= ~nxt_cnt[4*i+3];
      end
    end
  end

  assign count_o = cnt_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sign_ff <= 1'b1;
      dir_o <= 1'b1;
      carry_o <= 1'b0;
    end else begin
      sign_ff <= nxt_sign;
      dir_o <= nxt_dir;
      carry_o <= carry;
    end
  end

  assign sign_o = sign_ff;

  // ==========================================================
  // Variable modulus compare and clear pulse
  // The word is compared as raw nibbles, so it is BCD in decade mode.
  // Software must keep the direction up here; no check is made.
  assign match = ctrl_ff[CTRL_MODEN] && !clr_active &&
                 (cnt_ff == mod_ff[W-1:0]);

  always_comb begin
    if (match) begin
      nxt_clr = CLR_CNT_LOAD;
    end else if (clr_active) begin
      nxt_clr = 5'(clr_ff - 5'h01);
    end else begin
      nxt_clr = 5'h00;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clr_ff <= 5'h00;
      clear_n_o <= 1'b1;
      match_o <= 1'b0;
    end else begin
      clr_ff <= nxt_clr;
      clear_n_o <= (nxt_clr == 5'h00);
      match_o <= match;
    end
  end

  // ==========================================================
  // Rate selector
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_ff <= 8'h00;
    end else begin
      div_ff[3:0] <= 4'(div_ff[3:0] + 4'h1);
      if (div_ff[3:0] == HEX_MAX) begin
        div_ff[7:4] <= 4'(div_ff[7:4] + 4'h1);
      end
    end
  end

  // One register stage for every ratio keeps the latency equal
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rate_o <= 1'b0;
      rate_n_o <= 1'b0;
    end else if (ctrl_ff[CTRL_INH]) begin
      rate_o <= 1'b0;
      rate_n_o <= 1'b0;
    end else begin
      rate_o <= div_ff[ctrl_ff[CTRL_SEL_LSB +: 3]];
      rate_n_o <= ~div_ff[ctrl_ff[CTRL_SEL_LSB +: 3]];
    end
  end

endmodule

/* tb/csr_dec_model.sv */
`timescale 1ns/1ps
// ==========
// Downstream 1-of-16 decoder
module csr_dec_model (
  input wire logic [2:0] low_i,
  input wire logic msb_n_i,
  output logic [15:0] line_o
);
  // Rebuilds the MSB with a local inverter on the complemented pin
  assign line_o = 16'h1 << {~msb_n_i, low_i};
endmodule

/* tb/csr_top_sva.sv */
`timescale 1ns/1ps
// ==========
// Port checker
module csr_top_sva #(
  parameter int STAGES = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [4*STAGES-1:0] count_o,
  input wire logic [STAGES-1:0] msb_n_o,
  input wire logic sign_o,
  input wire logic match_o,
  input wire logic clear_n_o,
  input wire logic rate_o,
  input wire logic rate_n_o
);
  logic [STAGES-1:0] msbs;
  always_comb begin
    for (int i = 0; i < STAGES; i++) begin
      msbs[i] = count_o[4*i+3];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  chk_msb_pair: assert property (msb_n_o == ~msbs)
    else $error("msb complement wrong");
  chk_rate_pair: assert property (!(rate_o && rate_n_o))
    else $error("rate outputs both high");
  chk_clear_len: assert property ($fell(clear_n_o) |=> (!clear_n_o)[*8] ##1 clear_n_o)
    else $error("clear length wrong");
  chk_match_clear: assert property ($rose(match_o) |-> $fell(clear_n_o))
    else $error("match without clear");
  chk_match_pulse: assert property (match_o |=> !match_o)
    else $error("match not a pulse");
  chk_clear_zero: assert property (!clear_n_o |-> count_o == '0)
    else $error("count not held at zero");
  chk_sign_new: assert property ($changed(sign_o) |-> count_o == 1)
    else $error("sign change off one");
  chk_sign_cross: assert property ($changed(sign_o) |-> $past(count_o) == '0)
    else $error("sign change off zero");
  cover property ($fell(clear_n_o));
  cover property ($changed(sign_o));
  cover property ($rose(rate_o));
endmodule

bind csr_top csr_top_sva #(.STAGES(STAGES)) u_sva (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .count_o, .msb_n_o, .sign_o, .match_o, .clear_n_o, .rate_o, .rate_n_o);

/* tb/tb_top.sv */
`timescale 1ns/1ps
// ==========
// Bench
module tb_top;
  import csr_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, q;
  logic [15:0] count_o, last, pv, line;
  logic [3:0] msb_n_o;
  logic wb_ack_o, sign_o, dir_o, carry_o, match_o, clear_n_o, rate_o, rate_n_o;
  int n_mismatch = 0;
  int samples_checked = 0;
  int wd, s, hi;
  bit trk = 0;
  bit up = 0;
  csr_top u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o, .count_o, .msb_n_o, .sign_o,
    .dir_o, .carry_o, .match_o, .clear_n_o, .rate_o, .rate_n_o);
  csr_dec_model u_dec (.low_i(count_o[2:0]), .msb_n_i(msb_n_o[0]), .line_o(line));
  function logic [15:0] bcd(input int a);
    return 16'((a / 10) << 4 | a % 10);
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task test_done();
    if (n_mismatch == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Every open-ended wait goes through here, so a hang ends in the report
  task tick();
    @(negedge clk_i);
    wd++;
    if (wd > 3000) begin
      n_mismatch++;
      test_done();
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wd = 0;
    do tick(); while (wb_ack_o !== 1'b1);
    @(posedge clk_i);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task rise();
    wd = 0;
    while (rate_o !== 1'b0) tick();
    while (rate_o !== 1'b1) tick();
  endtask
  // Signed reference: each count step moves it by one
  always @(negedge clk_i) begin
    if (clear_n_o) pv = count_o;
    if (trk && count_o !== last) begin
      s = up ? s + 1 : s - 1;
      chk(count_o, bcd(s < 0 ? -s : s));
      if (s != 0) chk(sign_o, s > 0);
      chk(dir_o, 32'((s != 0) && (up == (s > 0))));
      chk(carry_o, 32'(last == 16'h0));
      chk(line, 16'h1 << count_o[3:0]);
      last = count_o;
    end
  end
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, ADDR_CTRL, 32'h0);
    chk(q, CTRL_RST);
    wb(1'b1, ADDR_CTRL, 32'h0);
    wb(1'b0, ADDR_COUNT, 32'h0);
    last = q[15:0];
    s = q[15:0];
    chk(count_o, q);
    wb(1'b0, ADDR_MOD, 32'h0);
    chk(q, MOD_RST);
    wb(1'b0, 8'h10, 32'h0);
    chk(q, 32'h0);
    trk = 1;
    wb(1'b1, ADDR_CTRL, 32'h5);
    wd = 0;
    while (s != -12) tick();
    wb(1'b1, ADDR_CTRL, 32'h4);
    repeat (2) @(negedge clk_i);
    up = 1;
    wb(1'b1, ADDR_CTRL, 32'h7);
    wd = 0;
    while (s != 3) tick();
    wb(1'b1, ADDR_CTRL, 32'h6);
    repeat (2) @(negedge clk_i);
    trk = 0;
    wb(1'b1, ADDR_MOD, 32'h12);
    wb(1'b1, ADDR_CTRL, 32'hf);
    wd = 0;
    while (clear_n_o !== 1'b0) tick();
    chk(pv, 32'h12);
    chk(count_o, 32'h0);
    for (int k = 0; k < 8; k++) begin
      wb(1'b1, ADDR_CTRL, 32'(k) << CTRL_SEL_LSB);
      // First rise may mix the old and new select; measure a clean period
      rise();
      rise();
      rise();
      chk(wd, 32'h1 << (k + 1));
      chk(rate_n_o, 32'h0);
    end
    wb(1'b1, ADDR_CTRL, 32'hf0);
    @(negedge clk_i);
    hi = 0;
    repeat (300) begin
      @(negedge clk_i);
      hi += rate_o | rate_n_o;
    end
    chk(hi, 32'h0);
    test_done();
  end
endmodule
